// file: logic/adcc_cfg.svh
/*
 converter control constants: register indices, field positions, reset
 values and timing counts. assumes inclusion by bare name.
*/
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
`define ADCC_IDX_MAIN     8'h00
`define ADCC_IDX_CLKDIV   8'h01
`define ADCC_IDX_REF      8'h02
`define ADCC_IDX_EVT      8'h03
`define ADCC_IDX_IENCLR   8'h04
`define ADCC_IDX_IENSET   8'h05
`define ADCC_IDX_FLAGS    8'h06
`define ADCC_IDX_BUSY     8'h20
`define ADCC_IDX_RESULT   8'h24
`define ADCC_MAIN_SRST    0
`define ADCC_MAIN_ENABLE  1
`define ADCC_MAIN_FOLLOW  5
`define ADCC_MAIN_MASK    8'he3
`define ADCC_REF_COMP     7
`define ADCC_REF_MASK     8'h8f
`define ADCC_EVT_WINEO    5
`define ADCC_EVT_RESEO    4
`define ADCC_EVT_STINV    3
`define ADCC_EVT_FLINV    2
`define ADCC_EVT_STEI     1
`define ADCC_EVT_FLEI     0
`define ADCC_EVT_MASK     8'h3f
`define ADCC_CLKDIV_MASK  8'h07
`define ADCC_IRQ_WIN      2
`define ADCC_IRQ_OVR      1
`define ADCC_IRQ_RES      0
`define ADCC_RESET_BYTE   8'h00
`define ADCC_SYNC_STAGES  2
`endif

// file: logic/adcc_control.sv
/*
 converter control registers: apb slave, enable and soft reset handshake
 into the converter clock domain, follower gating, event input/output
 gating, interrupt enables and flags.
 assumes: convClk is the converter clock, conversion status arrives as
 convClk-domain pulses, master settings come from logic on clk.
*/
// The APB register port was left to the implementer.
// Contract
// RULE1 - enable reads back at once; busy flag clears after converter domain takes it
// RULE2 - follower enable makes enable, divider, invert, event enables follow master
// RULE3 - soft reset one clears all registers except debug and disables converter
// RULE4 - soft reset write discards all other bits of that same access
// RULE5 - soft reset bit and its busy flag read one until reset finishes
// RULE6 - divider code 0..7 selects peripheral clock divided by 2..256
// RULE7 - divider, reference and event registers writable only while disabled
// RULE8 - reference select field four bits, codes 6 to 15 reserved
// RULE9 - bit 7 of reference control drives buffer offset compensation
// RULE10 - window event output enable gates a window match event out
// RULE11 - result event output enable gates a result available event out
// RULE12 - invert bits invert start and flush inputs before edge detection
// RULE13 - start event input enable lets start events trigger conversions
// RULE14 - flush event input enable lets flush events abort and restart
// RULE15 - writing one to enable clear clears matching interrupt enable
// RULE16 - writing one to enable set sets matching interrupt enable
// RULE17 - enable set and clear read the same enable register
// RULE18 - interrupt request while any flag and its enable are both one
// RULE19 - window flag sets the converter cycle after a window match
// RULE20 - window and result flags clear on write one or result read
// RULE21 - overrun flag sets on result overwrite unread, clears by write one
// RULE22 - result flag sets when a result becomes available
// RULE23 - a flag set in the same cycle as its clear wins
`include "adcc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module adcc_control #(
	parameter bit IS_FOLLOWER = 1'b1
) (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 convClk,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [15:0]          resultValue,
	input  wire logic                 convResultPulse,
	input  wire logic                 convWindowPulse,
	input  wire logic                 startEventIn,
	input  wire logic                 flushEventIn,
	input  wire logic                 masterEnable,
	input  wire logic [2:0]           masterClockDiv,
	input  wire logic [3:0]           masterEventCfg,
	output adcc_pkg::adcc_analog_s    analogCtrl,
	output adcc_pkg::adcc_events_s    eventsOut,
	output logic                      irqRequest
);
	////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] mainControl;
	logic [7:0] clockDividerSelect;
	logic [7:0] referenceControl;
	logic [7:0] eventControl;
	logic [2:0] irqEnable;
	logic [2:0] irqFlags;
	logic       resultUnread;
	logic       enableBusy;
	logic       resetBusy;
	logic       convEnabled;
	logic       enReq;
	logic       srReq;
	logic       enAck0, enAck1;
	logic       srAck0, srAck1;
	logic       cvEn0, cvEn1;
	logic       cvSr0, cvSr1;
	logic       resTog, winTog;
	logic [2:0] resSync, winSync;
	logic [1:0] stSync, flSync;
	logic       stPrev, flPrev;
	logic [7:0] divCount;
	logic       divClkOut;
	adcc_pkg::adcc_sync_e syncState;

	////////////////////////////////////////////////////////////////////
	// apb decode
	logic       access;
	logic       wr;
	logic       rd;
	logic [7:0] wb;
	logic [5:0] idx;
	logic       follow;
	logic       effEnable;
	logic [2:0] effDiv;
	logic [3:0] effEvt;
	logic       srWrite;
	logic       locked;
	assign access = psel && penable;
	assign wr = access && pwrite && !resetBusy;
	assign rd = access && !pwrite;
	assign wb = pwdata[7:0];
	assign idx = paddr[7:2];
	assign follow = IS_FOLLOWER && mainControl[`ADCC_MAIN_FOLLOW];
	assign srWrite = wr && idx == 6'(`ADCC_IDX_MAIN)
		&& wb[`ADCC_MAIN_SRST];
	// converter state only through the acknowledge synchroniser
	assign locked = mainControl[`ADCC_MAIN_ENABLE] || enAck1;
	// follower takes master settings
	assign effEnable = follow ? masterEnable
		: mainControl[`ADCC_MAIN_ENABLE]; // [RULE2]
	assign effDiv = follow ? masterClockDiv
		: clockDividerSelect[2:0]; // [RULE2]
	assign effEvt = follow ? masterEventCfg
		: eventControl[3:0]; // [RULE2]

	////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mainControl <= `ADCC_RESET_BYTE;
			clockDividerSelect <= `ADCC_RESET_BYTE;
			referenceControl <= `ADCC_RESET_BYTE;
			eventControl <= `ADCC_RESET_BYTE;
			irqEnable <= 3'h0;
		end else if (srWrite) begin
			mainControl <= 8'h01; // [RULE3] [RULE4] [RULE5]
			clockDividerSelect <= `ADCC_RESET_BYTE; // [RULE3]
			referenceControl <= `ADCC_RESET_BYTE;
			eventControl <= `ADCC_RESET_BYTE;
			irqEnable <= 3'h0;
		end else begin
			if (resetBusy && syncState == adcc_pkg::SYNC_BACK && !srAck1)
				mainControl[`ADCC_MAIN_SRST] <= 1'b0; // [RULE5]
			if (wr) begin
				unique case (idx)
				6'(`ADCC_IDX_MAIN): mainControl <= wb & (IS_FOLLOWER
					? `ADCC_MAIN_MASK : 8'hc2); // [RULE1]
				6'(`ADCC_IDX_CLKDIV): if (!locked)
					clockDividerSelect <= wb & `ADCC_CLKDIV_MASK; // [RULE7]
				6'(`ADCC_IDX_REF): if (!locked)
					referenceControl <= wb & `ADCC_REF_MASK; // [RULE7]
				6'(`ADCC_IDX_EVT): if (!locked)
					eventControl <= wb & `ADCC_EVT_MASK; // [RULE7]
				6'(`ADCC_IDX_IENCLR):
					irqEnable <= irqEnable & ~wb[2:0]; // [RULE15]
				6'(`ADCC_IDX_IENSET):
					irqEnable <= irqEnable | wb[2:0]; // [RULE16]
				default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// enable / soft reset handshake
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncState <= adcc_pkg::SYNC_IDLE;
			enReq <= 1'b0;
			srReq <= 1'b0;
			enableBusy <= 1'b0;
			resetBusy <= 1'b0;
		end else begin
			unique case (syncState)
			adcc_pkg::SYNC_IDLE: begin
				if (srWrite) begin
					srReq <= 1'b1;
					enReq <= 1'b0;
					resetBusy <= 1'b1; // [RULE5]
					syncState <= adcc_pkg::SYNC_WAIT;
				end else if (effEnable != enReq) begin
					enReq <= effEnable;
					enableBusy <= 1'b1; // [RULE1]
					syncState <= adcc_pkg::SYNC_WAIT;
				end
			end
			adcc_pkg::SYNC_WAIT: begin
				if (srAck1 == srReq && enAck1 == enReq) begin
					srReq <= 1'b0;
					syncState <= adcc_pkg::SYNC_BACK;
				end
			end
			adcc_pkg::SYNC_BACK: begin
				if (!srAck1) begin
					enableBusy <= 1'b0; // [RULE1]
					resetBusy <= 1'b0; // [RULE5]
					syncState <= adcc_pkg::SYNC_IDLE;
				end
			end
			default: syncState <= adcc_pkg::SYNC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			enAck0 <= 1'b0;
			enAck1 <= 1'b0;
			srAck0 <= 1'b0;
			srAck1 <= 1'b0;
		end else begin
			enAck0 <= convEnabled;
			enAck1 <= enAck0;
			srAck0 <= cvSr1;
			srAck1 <= srAck0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// converter clock domain
	always_ff @(posedge convClk or posedge reset) begin
		if (reset) begin
			cvEn0 <= 1'b0;
			cvEn1 <= 1'b0;
			cvSr0 <= 1'b0;
			cvSr1 <= 1'b0;
			convEnabled <= 1'b0;
			resTog <= 1'b0;
			winTog <= 1'b0;
		end else begin
			cvEn0 <= enReq;
			cvEn1 <= cvEn0;
			cvSr0 <= srReq;
			cvSr1 <= cvSr0;
			convEnabled <= cvEn1 && !cvSr1; // [RULE1] [RULE3]
			if (convResultPulse)
				resTog <= ~resTog;
			if (convWindowPulse)
				winTog <= ~winTog; // [RULE19]
		end
	end

	////////////////////////////////////////////////////////////////////
	// events and flags
	logic resEvt, winEvt, stIn, flIn, stEdge, flEdge, resRead;
	assign resEvt = resSync[2] ^ resSync[1];
	assign winEvt = winSync[2] ^ winSync[1];
	assign stIn = stSync[1] ^ effEvt[`ADCC_EVT_STINV]; // [RULE12]
	assign flIn = flSync[1] ^ effEvt[`ADCC_EVT_FLINV]; // [RULE12]
	assign stEdge = stIn && !stPrev;
	assign flEdge = flIn && !flPrev;
	assign resRead = rd && idx == 6'(`ADCC_IDX_RESULT);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			resSync <= 3'h0;
			winSync <= 3'h0;
			stSync <= 2'h0;
			flSync <= 2'h0;
			stPrev <= 1'b0;
			flPrev <= 1'b0;
			eventsOut <= '0;
		end else begin
			resSync <= {resSync[1:0], resTog};
			winSync <= {winSync[1:0], winTog};
			stSync <= {stSync[0], startEventIn};
			flSync <= {flSync[0], flushEventIn};
			stPrev <= stIn;
			flPrev <= flIn;
			// flush has priority over start
			eventsOut.flushConversion <= enAck1 && flEdge
				&& effEvt[`ADCC_EVT_FLEI]; // [RULE14]
			eventsOut.startConversion <= enAck1 && stEdge
				&& effEvt[`ADCC_EVT_STEI]
				&& !(flEdge && effEvt[`ADCC_EVT_FLEI]); // [RULE13]
			eventsOut.resultEvent <= resEvt
				&& eventControl[`ADCC_EVT_RESEO]; // [RULE11]
			eventsOut.windowEvent <= winEvt
				&& eventControl[`ADCC_EVT_WINEO]; // [RULE10]
		end
	end

	logic [2:0] flagClr, flagSet;
	assign flagClr = ((wr && idx == 6'(`ADCC_IDX_FLAGS)) ? wb[2:0] : 3'h0)
		| (resRead ? 3'b101 : 3'h0); // [RULE20] [RULE21]
	assign flagSet = {winEvt, resEvt && resultUnread && !resRead,
		resEvt}; // [RULE19] [RULE21] [RULE22]

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irqFlags <= 3'h0;
			resultUnread <= 1'b0;
		end else if (srWrite) begin
			irqFlags <= 3'h0; // [RULE3]
			resultUnread <= 1'b0;
		end else begin
			irqFlags <= (irqFlags & ~flagClr) | flagSet; // [RULE23]
			if (resEvt)
				resultUnread <= 1'b1;
			else if (resRead)
				resultUnread <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			irqRequest <= 1'b0;
		else
			irqRequest <= |(irqFlags & irqEnable); // [RULE18]
	end

	////////////////////////////////////////////////////////////////////
	// divided converter clock and analog controls
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			divCount <= 8'h00;
			divClkOut <= 1'b0;
		end else begin
			divCount <= divCount + 8'h01;
			divClkOut <= divCount[effDiv]; // [RULE6]
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			analogCtrl <= '0;
		else begin
			analogCtrl.refSelect <= referenceControl[3:0]; // [RULE8]
			analogCtrl.refBufferCompEn
				<= referenceControl[`ADCC_REF_COMP]; // [RULE9]
			analogCtrl.clockDivideSel <= effDiv; // [RULE6]
			analogCtrl.convEnable <= enAck1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read data
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable && !pwrite) begin
				unique case (paddr[7:2])
				6'(`ADCC_IDX_MAIN): prdata <= {24'h0, mainControl};
				6'(`ADCC_IDX_CLKDIV): prdata <= {24'h0, clockDividerSelect};
				6'(`ADCC_IDX_REF): prdata <= {24'h0, referenceControl};
				6'(`ADCC_IDX_EVT): prdata <= {24'h0, eventControl};
				6'(`ADCC_IDX_IENCLR),
				6'(`ADCC_IDX_IENSET):
					prdata <= {29'h0, irqEnable}; // [RULE17]
				6'(`ADCC_IDX_FLAGS): prdata <= {29'h0, irqFlags};
				6'(`ADCC_IDX_BUSY):
					prdata <= {30'h0, enableBusy, resetBusy}; // [RULE5]
				6'(`ADCC_IDX_RESULT): prdata <= {16'h0, resultValue};
				default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	busy_pair_a: assert property (@(posedge clk) disable iff (reset)
		mainControl[`ADCC_MAIN_SRST] |-> resetBusy) // [RULE5]
		else $error("soft reset bit without busy");
	srst_clear_a: assert property (@(posedge clk) disable iff (reset)
		srWrite |=> clockDividerSelect == 8'h0 && irqEnable == 3'h0
		&& !mainControl[`ADCC_MAIN_ENABLE]) // [RULE3] [RULE4]
		else $error("soft reset left state");
	irq_out_a: assert property (@(posedge clk) disable iff (reset)
		|(irqFlags & irqEnable) |=> irqRequest) // [RULE18]
		else $error("irq not raised");
	ien_set_a: assert property (@(posedge clk) disable iff (reset || srWrite)
		wr && idx == 6'(`ADCC_IDX_IENSET) |=> (irqEnable & $past(wb[2:0]))
		== $past(wb[2:0])) // [RULE16]
		else $error("enable set lost");
	ien_clr_a: assert property (@(posedge clk) disable iff (reset)
		wr && idx == 6'(`ADCC_IDX_IENCLR) |=> (irqEnable & $past(wb[2:0]))
		== 3'h0) // [RULE15]
		else $error("enable clear lost");
	res_flag_a: assert property (@(posedge clk) disable iff (reset || srWrite)
		resEvt |=> irqFlags[`ADCC_IRQ_RES]) // [RULE22] [RULE23]
		else $error("result flag missed");
	lock_cfg_a: assert property (@(posedge clk) disable iff (reset || srWrite)
		locked |=> $stable(referenceControl)) // [RULE7]
		else $error("locked register changed");
	en_busy_a: assert property (@(posedge clk) disable iff (reset)
		syncState == adcc_pkg::SYNC_IDLE && !srWrite && effEnable != enReq
		|=> enableBusy) // [RULE1]
		else $error("enable busy not set");
endmodule
`default_nettype wire

// file: logic/adcc_pkg.sv
/*
 converter control types. assumes nothing beyond a sv compiler.
*/
package adcc_pkg;
	typedef struct packed {
		logic [3:0] refSelect;
		logic       refBufferCompEn;
		logic [2:0] clockDivideSel;
		logic       convEnable;
	} adcc_analog_s;
	typedef struct packed {
		logic startConversion;
		logic flushConversion;
		logic resultEvent;
		logic windowEvent;
	} adcc_events_s;
	typedef enum logic [1:0] {
		SYNC_IDLE = 2'b00,
		SYNC_WAIT = 2'b01,
		SYNC_BACK = 2'b10
	} adcc_sync_e;
endpackage

// file: testbench/adcc_conv_model.sv
/*
 converter stand-in: free-running converter clock, one result pulse a
 few converter cycles after each start or flush request.
 assumes: requests are single clk-cycle pulses from the control block.
*/
`timescale 1ns/1ns
`default_nettype none
module adcc_conv_model (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic startReq,
	input  wire logic flushReq,
	input  wire logic winMatch,
	output logic      convClk,
	output logic      convResultPulse,
	output logic      convWindowPulse
);
	logic       reqToggle;
	logic [2:0] reqSync;
	logic [1:0] delay;
	logic       busy;
	initial convClk = 1'b0;
	always #130 convClk = ~convClk;
	// a toggle carries a one-cycle request safely into the slower clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reqToggle <= 1'b0;
		end else if (startReq || flushReq) begin
			reqToggle <= ~reqToggle;
		end
	end
	always_ff @(posedge convClk or posedge reset) begin
		if (reset) begin
			reqSync <= 3'h0;
			delay <= 2'h0;
			busy <= 1'b0;
			convResultPulse <= 1'b0;
			convWindowPulse <= 1'b0;
		end else begin
			reqSync <= {reqSync[1:0], reqToggle};
			convResultPulse <= 1'b0;
			convWindowPulse <= 1'b0;
			if (reqSync[2] != reqSync[1]) begin
				busy <= 1'b1;
				delay <= 2'h2;
			end else if (busy) begin
				delay <= delay - 2'h1;
				if (delay == 2'h0) begin
					busy <= 1'b0;
					convResultPulse <= 1'b1;
					convWindowPulse <= winMatch;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
/*
 self-checking bench for the converter control block over apb.
 assumes: the converter model answers each start or flush with a result.
*/
`include "adcc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic                   clk;
	logic                   reset;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [7:0]             paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic [15:0]            resultValue;
	logic                   convClk;
	logic                   convResultPulse;
	logic                   convWindowPulse;
	logic                   startEventIn;
	logic                   flushEventIn;
	logic                   masterEnable;
	logic [2:0]             masterClockDiv;
	logic [3:0]             masterEventCfg;
	logic                   winMatch;
	logic                   irqRequest;
	adcc_pkg::adcc_analog_s analogCtrl;
	adcc_pkg::adcc_events_s eventsOut;
	logic [31:0]            rdata;
	logic                   rerr;
	logic [7:0]             cfgVal [3];
	logic [7:0]             cfgIdx [3];
	logic [7:0]             cfgMask [3];
	int                     evCnt [4];
	int                     n_fail;
	int                     total_checks;
	int                     i;
	adcc_control adcc_control_i (.clk(clk), .reset(reset), .convClk(convClk),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.resultValue(resultValue), .convResultPulse(convResultPulse),
		.convWindowPulse(convWindowPulse), .startEventIn(startEventIn),
		.flushEventIn(flushEventIn), .masterEnable(masterEnable),
		.masterClockDiv(masterClockDiv), .masterEventCfg(masterEventCfg),
		.analogCtrl(analogCtrl), .eventsOut(eventsOut),
		.irqRequest(irqRequest));
	adcc_conv_model adcc_conv_model_i (.clk(clk), .reset(reset),
		.startReq(eventsOut.startConversion),
		.flushReq(eventsOut.flushConversion), .winMatch(winMatch),
		.convClk(convClk), .convResultPulse(convResultPulse),
		.convWindowPulse(convWindowPulse));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (eventsOut.startConversion === 1'b1) evCnt[0]++;
		if (eventsOut.flushConversion === 1'b1) evCnt[1]++;
		if (eventsOut.resultEvent === 1'b1) evCnt[2]++;
		if (eventsOut.windowEvent === 1'b1) evCnt[3]++;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] keep(input logic [7:0] m, input logic [7:0] v);
		return {24'h0, v & m};
	endfunction
	task results;
		if (n_fail == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_fail++;
			results;
		end
	endtask
	task chkRd(input string name, input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(name, rdata, exp);
	endtask
	task waitEv(input int k, input int n);
		int t;
		t = 0;
		while (evCnt[k] < n && t < 200) begin
			@(posedge clk);
			t++;
		end
		if (evCnt[k] < n) begin
			n_fail++;
			results;
		end
		repeat (6) @(posedge clk);
	endtask
	task waitBusy(input logic [31:0] m);
		int t;
		t = 0;
		do begin
			apb(1'b0, `ADCC_IDX_BUSY, 32'h0);
			t++;
		end while ((rdata & m) !== 32'h0 && t < 60);
		if ((rdata & m) !== 32'h0) begin
			n_fail++;
			results;
		end
	endtask
	task pulseStart;
		@(posedge clk);
		startEventIn <= 1'b0;
		repeat (4) @(posedge clk);
		startEventIn <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{resultValue, startEventIn, flushEventIn, winMatch} = '0;
		{masterEnable, masterClockDiv, masterEventCfg} = '0;
		evCnt = '{default: 0};
		n_fail = 0;
		total_checks = 0;
		cfgIdx = '{`ADCC_IDX_CLKDIV, `ADCC_IDX_REF, `ADCC_IDX_EVT};
		cfgMask = '{`ADCC_CLKDIV_MASK, `ADCC_REF_MASK, `ADCC_EVT_MASK};
		void'($urandom(32'h55d5fe2c));
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (i = 0; i < 7; i++) chkRd("reset value", 8'(i), 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped err", {31'h0, rerr}, 32'h1);
		chk("unmapped data", rdata, 32'h0);
		repeat (8) begin
			for (i = 0; i < 3; i++) begin
				cfgVal[i] = 8'($urandom);
				apb(1'b1, cfgIdx[i], {24'h0, cfgVal[i]});
				chkRd("config", cfgIdx[i], keep(cfgMask[i], cfgVal[i]));
			end
			chk("divider", 32'(analogCtrl.clockDivideSel), keep(8'h07, cfgVal[0]));
			chk("reference_select", 32'(analogCtrl.refSelect), keep(8'h0f, cfgVal[1]));
			chk("ref_buffer_comp_en", 32'(analogCtrl.refBufferCompEn), 32'(cfgVal[1][7]));
		end
		apb(1'b1, `ADCC_IDX_EVT, 32'h32);
		apb(1'b1, `ADCC_IDX_IENSET, 32'h7);
		chkRd("ien clear view", `ADCC_IDX_IENCLR, 32'h7);
		apb(1'b1, `ADCC_IDX_IENCLR, 32'h2);
		chkRd("ien set view", `ADCC_IDX_IENSET, 32'h5);
		apb(1'b1, `ADCC_IDX_MAIN, 32'h2);
		apb(1'b0, `ADCC_IDX_BUSY, 32'h0);
		chk("enable busy", rdata & 32'h2, 32'h2);
		chkRd("enable readback", `ADCC_IDX_MAIN, 32'h2);
		waitBusy(32'h2);
		chk("conv enable", 32'(analogCtrl.convEnable), 32'h1);
		apb(1'b1, `ADCC_IDX_CLKDIV, {24'h0, ~cfgVal[0]});
		chkRd("protected", `ADCC_IDX_CLKDIV, keep(8'h07, cfgVal[0]));
		apb(1'b1, `ADCC_IDX_REF, {24'h0, ~cfgVal[1]});
		chkRd("ref locked", `ADCC_IDX_REF, keep(8'h8f, cfgVal[1]));
		resultValue <= 16'($urandom);
		winMatch <= 1'b1;
		pulseStart;
		waitEv(2, 1);
		chk("window event", 32'(evCnt[3]), 32'h1);
		chkRd("flags", `ADCC_IDX_FLAGS, 32'h5);
		chk("irq set", {31'h0, irqRequest}, 32'h1);
		chkRd("result", `ADCC_IDX_RESULT, {16'h0, resultValue});
		chkRd("flags read clear", `ADCC_IDX_FLAGS, 32'h0);
		chk("irq clear", {31'h0, irqRequest}, 32'h0);
		for (i = 0; i < 2; i++) begin
			pulseStart;
			waitEv(2, 2 + i);
		end
		chkRd("overrun", `ADCC_IDX_FLAGS, 32'h7);
		apb(1'b1, `ADCC_IDX_FLAGS, 32'h0);
		chkRd("zero write", `ADCC_IDX_FLAGS, 32'h7);
		apb(1'b1, `ADCC_IDX_FLAGS, 32'h7);
		chkRd("one write", `ADCC_IDX_FLAGS, 32'h0);
		chk("start count", 32'(evCnt[0]), 32'h3);
		chkRd("result again", `ADCC_IDX_RESULT, {16'h0, resultValue});
		apb(1'b1, `ADCC_IDX_MAIN, 32'h0);
		waitBusy(32'h2);
		apb(1'b1, `ADCC_IDX_EVT, 32'h05);
		apb(1'b1, `ADCC_IDX_MAIN, 32'h2);
		waitBusy(32'h2);
		flushEventIn <= 1'b1;
		pulseStart;
		repeat (10) @(posedge clk);
		chk("start off", 32'(evCnt[0]), 32'h3);
		chk("flush inverted", 32'(evCnt[1]), 32'h0);
		flushEventIn <= 1'b0;
		waitEv(1, 1);
		repeat (40) @(posedge clk);
		chk("result gated", 32'(evCnt[2]), 32'h3);
		chk("window gated", 32'(evCnt[3]), 32'h3);
		chkRd("flush result", `ADCC_IDX_FLAGS, 32'h5);
		apb(1'b1, `ADCC_IDX_MAIN, 32'h3);
		apb(1'b0, `ADCC_IDX_MAIN, 32'h0);
		chk("reset bit", rdata & 32'h1, 32'h1);
		waitBusy(32'h1);
		chkRd("reset done", `ADCC_IDX_MAIN, 32'h0);
		for (i = 1; i < 7; i++) chkRd("after reset", 8'(i), 32'h0);
		chk("disabled", 32'(analogCtrl.convEnable), 32'h0);
		masterEnable <= 1'b1;
		masterClockDiv <= 3'($urandom);
		masterEventCfg <= 4'h2;
		apb(1'b1, `ADCC_IDX_MAIN, 32'h20);
		waitBusy(32'h2);
		chkRd("follower", `ADCC_IDX_MAIN, 32'h20);
		chk("follow enable", 32'(analogCtrl.convEnable), 32'h1);
		chk("follow div", 32'(analogCtrl.clockDivideSel), 32'(masterClockDiv));
		pulseStart;
		waitEv(0, 4);
		results;
	end
endmodule
`default_nettype wire
